/* logic/adc_dev_end.sv */
// converter end of the serial link, and the small fifo used on the host side
// assumes io_clk comes from the host and stands still outside transfers
`timescale 1ns/100ps

// word fifo held in flip-flops, valid and ready on both sides
module link_fifo #(
    parameter int WIDTH = adc_link_pkg::RESULT_W,
    parameter int DEPTH = adc_link_pkg::FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
        $error("fifo depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != (PW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule : link_fifo

module adc_dev_end #(
    parameter int CONV_CYCLES = adc_link_pkg::CONV_CYCLES
) (
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    adc_link_if.device      link,
    input  wire logic [9:0] analog_value,
    output logic            sampling,
    output logic      [3:0] sample_channel,
    output logic            converting
);
    localparam logic [3:0] LAST_CLK  = 4'(adc_link_pkg::MAX_CLOCKS - 1);
    localparam logic [3:0] TENTH     = 4'(adc_link_pkg::CONV_CLOCKS);
    localparam logic [3:0] NINTH     = 4'(adc_link_pkg::CONV_CLOCKS - 1);
    localparam logic [3:0] ADDR_END  = 4'(adc_link_pkg::ADDR_CLOCKS);
    localparam logic [3:0] SAMP_FROM = 4'(adc_link_pkg::SAMPLE_START);
    localparam int         CW        = $clog2(CONV_CYCLES + 1);
    localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);

    if (CONV_CYCLES < 1) begin : g_bad_conv
        $error("conversion must last at least one core cycle");
    end

    // link-clock domain
    logic       link_rst_n;
    logic [3:0] fall_cnt;
    logic [3:0] bit_idx;
    logic [3:0] addr_sh;
    logic [3:0] conv_ch;
    logic       start_tgl;
    logic       restart_view;

    // core domain
    logic          st_s1;
    logic          st_s2;
    logic          start_ack;
    logic          busy;
    logic [CW-1:0] conv_cnt;
    logic [3:0]    core_ch;
    logic [9:0]    result;
    logic [9:0]    next_result;
    logic          eoc_int;

    assign link_rst_n = reset_n & ~link.cs_n;

    // held select, result ready: present msb again
    assign restart_view = (fall_cnt == TENTH) & eoc_int;
    assign bit_idx      = restart_view ? 4'h0 : fall_cnt;

    // address register, ignored after four bits
    always_ff @(posedge link.io_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            addr_sh <= 4'h0;
        end else if (bit_idx < ADDR_END) begin
            addr_sh <= {addr_sh[2:0], link.addr};
        end
    end

    // falling edge counter of the current sequence
    // done is steady at the fall after the tenth: held transfers start
    // only once it is high, and a conversion outlasts one link period
    always_ff @(negedge link.io_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            fall_cnt <= 4'h0;
        end else if (restart_view) begin
            fall_cnt <= 4'h1;
        end else if (fall_cnt == LAST_CLK) begin
            fall_cnt <= 4'h0;
        end else begin
            fall_cnt <= fall_cnt + 4'h1;
        end
    end

    // tenth fall latches channel and requests a conversion
    always_ff @(negedge link.io_clk or negedge reset_n) begin
        if (!reset_n) begin
            start_tgl <= 1'b0;
            conv_ch   <= 4'h0;
        end else if (!link.cs_n && bit_idx == NINTH) begin
            start_tgl <= ~start_tgl;
            conv_ch   <= addr_sh;
        end
    end

    // serial output, msb at index 0, zeros from the tenth fall
    always_comb begin
        if (bit_idx < TENTH) begin
            link.dout = result[4'd9 - bit_idx];
        end else begin
            link.dout = 1'b0;
        end
    end

    assign link.dout_oe_n  = link.cs_n;
    assign sampling        = (bit_idx >= SAMP_FROM) & (bit_idx < TENTH);
    assign sample_channel  = addr_sh;

    // done low while a request is pending or converting
    assign eoc_int  = ~busy & (start_tgl == start_ack);
    assign link.eoc = eoc_int;
    assign converting = busy;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_s1 <= 1'b0;
            st_s2 <= 1'b0;
        end else begin
            st_s1 <= start_tgl;
            st_s2 <= st_s1;
        end
    end

    // channel to value, test levels are fixed codes
    always_comb begin
        case (core_ch)
            adc_link_pkg::CH_TEST_HALF: next_result = adc_link_pkg::RES_TEST_HALF;
            adc_link_pkg::CH_TEST_NEG:  next_result = adc_link_pkg::RES_TEST_NEG;
            adc_link_pkg::CH_TEST_POS:  next_result = adc_link_pkg::RES_TEST_POS;
            default:                    next_result = analog_value;
        endcase
    end

    // conversion timer in core cycles
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            start_ack <= 1'b0;
            busy      <= 1'b0;
            conv_cnt  <= '0;
            core_ch   <= 4'h0;
        end else if (!busy && st_s2 != start_ack) begin
            start_ack <= st_s2;
            busy      <= 1'b1;
            conv_cnt  <= '0;
            core_ch   <= conv_ch;
        end else if (busy && conv_cnt == CONV_LAST) begin
            busy      <= 1'b0;
        end else if (busy) begin
            conv_cnt  <= conv_cnt + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            result <= adc_link_pkg::RES_RESET;
        end else if (busy && conv_cnt == CONV_LAST) begin
            result <= next_result;
        end
    end
endmodule : adc_dev_end

/* logic/adc_host_end.sv */
// host end: makes the link clock, sends addresses, gathers result words
// assumes link_fifo is compiled first and the device answers per the link
`timescale 1ns/100ps
module adc_host_end #(
    parameter int HALF       = adc_link_pkg::LINK_HALF_CYCLES,
    parameter int FIFO_DEPTH = adc_link_pkg::FIFO_DEPTH
) (
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    adc_link_if.host        link,
    input  wire logic       req_valid,
    output logic            req_ready,
    input  wire logic [3:0] req_channel,
    input  wire logic [4:0] req_clocks,
    input  wire logic       req_hold_cs,
    output logic            res_valid,
    input  wire logic       res_ready,
    output logic      [9:0] res_data
);
    localparam logic [4:0] MIN_C = 5'(adc_link_pkg::MIN_CLOCKS);
    localparam logic [4:0] MAX_C = 5'(adc_link_pkg::MAX_CLOCKS);
    localparam logic [4:0] RES_C = 5'(adc_link_pkg::RESULT_W);
    localparam logic [7:0] HALF_LAST  = 8'(HALF - 1);
    localparam logic [7:0] SETUP_LAST = 8'(adc_link_pkg::CS_SETUP_CYCLES - 1);

    if (HALF < 3 || HALF > 255) begin : g_bad_half
        $error("link half period must be 3 to 255 core cycles");
    end
    if (3 * HALF >= adc_link_pkg::SLOW_WINDOW_CYCLES) begin : g_bad_win
        $error("link clock too slow for the slow-mode window");
    end

    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_LOW, ST_HIGH, ST_WAIT, ST_PUSH
    } host_state_t;

    host_state_t state;
    logic [7:0]  div_cnt;
    logic [4:0]  clk_cnt;
    logic [4:0]  clk_goal;
    logic [3:0]  tx;
    logic [9:0]  rx;
    logic        hold;
    logic        seen_low;
    logic        dout_s1;
    logic        dout_s2;
    logic        eoc_s1;
    logic        eoc_s2;
    logic        fifo_ready;
    logic [4:0]  next_goal;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            dout_s1 <= 1'b0;
            dout_s2 <= 1'b0;
            eoc_s1  <= 1'b0;
            eoc_s2  <= 1'b0;
        end else begin
            dout_s1 <= link.dout;
            dout_s2 <= dout_s1;
            eoc_s1  <= link.eoc;
            eoc_s2  <= eoc_s1;
        end
    end

    // clock count: held select 10 or 16, toggled 10 to 16
    always_comb begin
        if (req_hold_cs) begin
            next_goal = (req_clocks <= MIN_C) ? MIN_C : MAX_C;
        end else if (req_clocks < MIN_C) begin
            next_goal = MIN_C;
        end else if (req_clocks > MAX_C) begin
            next_goal = MAX_C;
        end else begin
            next_goal = req_clocks;
        end
    end

    assign req_ready = (state == ST_IDLE);
    assign link.addr = tx[3];

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state       <= ST_IDLE;
            link.cs_n   <= 1'b1;
            link.io_clk <= 1'b0;
            div_cnt     <= 8'h00;
            clk_cnt     <= 5'h00;
            clk_goal    <= 5'h00;
            tx          <= 4'h0;
            rx          <= 10'h000;
            hold        <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (req_valid) begin
                        link.cs_n <= 1'b0;
                        tx        <= req_channel;
                        clk_goal  <= next_goal;
                        hold      <= req_hold_cs;
                        clk_cnt   <= 5'h00;
                        div_cnt   <= 8'h00;
                        state     <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (div_cnt >= SETUP_LAST) begin
                        div_cnt <= 8'h00;
                        state   <= ST_LOW;
                    end else begin
                        div_cnt <= div_cnt + 8'h01;
                    end
                end
                ST_LOW: begin
                    if (div_cnt == HALF_LAST) begin
                        if (clk_cnt < RES_C) begin
                            rx <= {rx[8:0], dout_s2};
                        end
                        link.io_clk <= 1'b1;
                        div_cnt     <= 8'h00;
                        state       <= ST_HIGH;
                    end else begin
                        div_cnt <= div_cnt + 8'h01;
                    end
                end
                ST_HIGH: begin
                    if (div_cnt == HALF_LAST) begin
                        link.io_clk <= 1'b0;
                        tx          <= {tx[2:0], 1'b0};
                        clk_cnt     <= clk_cnt + 5'h01;
                        div_cnt     <= 8'h00;
                        // clocks run back to back, so the slow window holds
                        if (clk_cnt + 5'h01 == clk_goal) begin
                            state <= ST_WAIT;
                        end else begin
                            state <= ST_LOW;
                        end
                    end else begin
                        div_cnt <= div_cnt + 8'h01;
                    end
                end
                ST_WAIT: begin
                    if (!hold) begin
                        link.cs_n <= 1'b1;
                    end
                    if (seen_low && eoc_s2) begin
                        state <= ST_PUSH;
                    end
                end
                ST_PUSH: begin
                    if (fifo_ready) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // done must be seen low before its rise counts
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            seen_low <= 1'b0;
        end else if (state == ST_IDLE) begin
            seen_low <= 1'b0;
        end else if (state != ST_SETUP && !eoc_s2) begin
            seen_low <= 1'b1;
        end
    end

    link_fifo #(
        .WIDTH (adc_link_pkg::RESULT_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (core_clk),
        .reset_n   (reset_n),
        .in_valid  (state == ST_PUSH),
        .in_ready  (fifo_ready),
        .in_data   (rx),
        .out_valid (res_valid),
        .out_ready (res_ready),
        .out_data  (res_data)
    );
endmodule : adc_host_end

/* logic/adc_link_if.sv */
// the four-wire serial link plus conversion-done between host and device
// assumes the bench resolves dout from dout_oe_n (high means released)
`timescale 1ns/100ps
interface adc_link_if;
    logic cs_n;
    logic io_clk;
    logic addr;
    logic dout;
    logic dout_oe_n;
    logic eoc;

    modport device (
        input  cs_n,
        input  io_clk,
        input  addr,
        output dout,
        output dout_oe_n,
        output eoc
    );

    modport host (
        output cs_n,
        output io_clk,
        output addr,
        input  dout,
        input  eoc
    );
endinterface : adc_link_if

/* logic/adc_link_pkg.sv */
// constants shared by both ends of the serial converter link
// assumes both ends run their core logic on a 250 MHz core_clk
package adc_link_pkg;

    localparam int RESULT_W       = 10;
    localparam int ADDR_W         = 4;
    localparam int CNT_W          = 4;
    localparam int ADDR_CLOCKS    = 4;
    localparam int SAMPLE_START   = 4;
    localparam int CONV_CLOCKS    = 10;
    localparam int MIN_CLOCKS     = 10;
    localparam int MAX_CLOCKS     = 16;

    localparam int CORE_PERIOD_PS = 4000;
    localparam int CONV_TIME_NS   = 2000;
    localparam int CONV_CYCLES    =
        (CONV_TIME_NS * 1000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
    localparam int SLOW_WINDOW_NS = 9500;
    localparam int SLOW_WINDOW_CYCLES =
        (SLOW_WINDOW_NS * 1000) / CORE_PERIOD_PS;
    localparam int CS_SETUP_NS    = 16;
    localparam int CS_SETUP_CYCLES =
        (CS_SETUP_NS * 1000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
    localparam int LINK_HALF_CYCLES = 4;
    localparam int FIFO_DEPTH     = 8;

    localparam logic [3:0] CH_LAST_EXT  = 4'hA;
    localparam logic [3:0] CH_TEST_HALF = 4'hB;
    localparam logic [3:0] CH_TEST_NEG  = 4'hC;
    localparam logic [3:0] CH_TEST_POS  = 4'hD;

    localparam logic [9:0] RES_TEST_HALF = 10'h200;
    localparam logic [9:0] RES_TEST_NEG  = 10'h000;
    localparam logic [9:0] RES_TEST_POS  = 10'h3FF;
    localparam logic [9:0] RES_RESET     = 10'h000;

endpackage : adc_link_pkg

/* test/adc_link_checker.sv */
// assertions on the serial converter link between host end and device end
// assumes it sits beside the link interface in the bench top module
`timescale 1ns/100ps
module adc_link_checker #(
    parameter int CONV_CYCLES = adc_link_pkg::CONV_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic io_clk,
    input wire logic addr,
    input wire logic dout,
    input wire logic dout_oe_n,
    input wire logic eoc
);
    localparam int SPAN_MAX = CONV_CYCLES + 8;

    logic [4:0] fall_idx;
    logic [9:0] low_cnt;

    // link clock falls since chip select fell, as the device indexes them
    always_ff @(negedge io_clk or posedge cs_n or negedge reset_n) begin
        if (!reset_n) begin
            fall_idx <= 5'h00;
        end else if (cs_n) begin
            fall_idx <= 5'h00;
        end else if (fall_idx == 5'h10 || (fall_idx == 5'h0A && eoc)) begin
            fall_idx <= 5'h01;
        end else begin
            fall_idx <= fall_idx + 5'h01;
        end
    end

    // core cycles spent with conversion-done low
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            low_cnt <= 10'h000;
        end else if (eoc) begin
            low_cnt <= 10'h000;
        end else if (low_cnt != 10'h3FF) begin
            low_cnt <= low_cnt + 10'h001;
        end
    end

    sequence tenth_fall_s;
        $fell(eoc) && !cs_n;
    endsequence

    sequence conv_busy_s;
        !eoc [*4];
    endsequence

    oe_tracks_cs_a: assert property (
        @(posedge core_clk) disable iff (!reset_n) dout_oe_n == cs_n)
        else $error("output enable differs from chip select");
    eoc_tenth_fall_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        $fell(eoc) |-> fall_idx == 5'h0A && !cs_n)
        else $error("done fell away from the tenth clock fall");
    eoc_low_hold_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        tenth_fall_s |=> conv_busy_s)
        else $error("done rose too soon after falling");
    eoc_low_span_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        $rose(eoc) |-> low_cnt >= CONV_CYCLES && low_cnt <= SPAN_MAX)
        else $error("conversion length out of range");
    eoc_idle_high_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (fall_idx >= 5'h01 && fall_idx <= 5'h09) |-> eoc)
        else $error("done low before ten clocks");
    tail_zero_a: assert property (
        @(posedge io_clk) disable iff (!reset_n)
        !cs_n && fall_idx >= 5'h0A && fall_idx <= 5'h0F
        && !(fall_idx == 5'h0A && eoc) |-> !dout)
        else $error("serial output not low after tenth fall");
    idle_clock_still_a: assert property (
        @(posedge core_clk) disable iff (!reset_n) cs_n |-> !io_clk)
        else $error("link clock high while deselected");
    addr_moves_low_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        $changed(addr) |-> !io_clk)
        else $error("address changed while link clock high");
endmodule : adc_link_checker

/* test/adc_serial_conversion_control_tb.sv */
// bench for the serial converter link: host end facing device end
// assumes package, interface, fifo and both ends are compiled first
`timescale 1ns/100ps
module adc_serial_conversion_control_tb;
    localparam int CONV = 8;

    logic       core_clk;
    logic       reset_n;
    logic [9:0] analog_value;
    logic       sampling;
    logic [3:0] sample_channel;
    logic       converting;
    logic       req_valid;
    logic       req_ready;
    logic [3:0] req_channel;
    logic [4:0] req_clocks;
    logic       req_hold_cs;
    logic       res_valid;
    logic       res_ready;
    logic [9:0] res_data;
    logic [9:0] prev_res;
    logic [9:0] exp_q[$];
    logic [3:0] chs[0:8]  = '{4'hB, 4'hC, 4'hD, 4'h0, 4'hA, 4'hE, 4'hF,
                              4'h7, 4'h5};
    logic [4:0] lens[0:8] = '{5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F,
                              5'h10, 5'h0A, 5'h0B};
    int         n_errors;
    int         checked;
    int         rises;

    adc_link_if u_adc_link_if ();

    adc_dev_end #(.CONV_CYCLES(CONV)) u_adc_dev_end (
        .core_clk       (core_clk),
        .reset_n        (reset_n),
        .link           (u_adc_link_if.device),
        .analog_value   (analog_value),
        .sampling       (sampling),
        .sample_channel (sample_channel),
        .converting     (converting)
    );

    adc_host_end #(.HALF(4), .FIFO_DEPTH(8)) u_adc_host_end (
        .core_clk    (core_clk),
        .reset_n     (reset_n),
        .link        (u_adc_link_if.host),
        .req_valid   (req_valid),
        .req_ready   (req_ready),
        .req_channel (req_channel),
        .req_clocks  (req_clocks),
        .req_hold_cs (req_hold_cs),
        .res_valid   (res_valid),
        .res_ready   (res_ready),
        .res_data    (res_data)
    );

    adc_link_checker #(.CONV_CYCLES(CONV)) u_adc_link_checker (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .cs_n      (u_adc_link_if.cs_n),
        .io_clk    (u_adc_link_if.io_clk),
        .addr      (u_adc_link_if.addr),
        .dout      (u_adc_link_if.dout),
        .dout_oe_n (u_adc_link_if.dout_oe_n),
        .eoc       (u_adc_link_if.eoc)
    );

    initial core_clk = 1'b0;
    always #2 core_clk = ~core_clk;

    // link clock rises within the current transfer
    always @(posedge u_adc_link_if.io_clk) begin
        if (!u_adc_link_if.cs_n) begin
            rises = rises + 1;
        end
    end

    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    function automatic logic [9:0] conv_of(input logic [3:0] ch,
                                           input logic [9:0] val);
        case (ch)
            4'hB: conv_of = adc_link_pkg::RES_TEST_HALF;
            4'hC: conv_of = adc_link_pkg::RES_TEST_NEG;
            4'hD: conv_of = adc_link_pkg::RES_TEST_POS;
            default: conv_of = val;
        endcase
    endfunction : conv_of

    // one transfer; word expected back is the previous conversion
    task automatic do_xfer(input logic [3:0] ch, input logic [4:0] nclk,
                           input logic hold, input logic [9:0] val);
        int i;
        for (i = 0; i < 3000 && req_ready !== 1'b1; i++) @(negedge core_clk);
        analog_value = val;
        req_channel  = ch;
        req_clocks   = nclk;
        req_hold_cs  = hold;
        req_valid    = 1'b1;
        @(negedge core_clk);
        req_valid = 1'b0;
        rises     = 0;
        exp_q.push_back(prev_res);
        prev_res = conv_of(ch, val);
        for (i = 0; i < 3000 && sampling !== 1'b1; i++) @(negedge core_clk);
        check({6'h00, sample_channel}, {6'h00, ch});
        if (!hold) begin
            for (i = 0; i < 3000 && u_adc_link_if.cs_n !== 1'b1; i++) begin
                @(negedge core_clk);
            end
            check(10'(rises), {5'h00, nclk});
        end
    endtask : do_xfer

    task automatic pop_all;
        int i;
        while (exp_q.size() > 0) begin
            for (i = 0; i < 3000 && res_valid !== 1'b1; i++) begin
                @(negedge core_clk);
            end
            check(res_data, exp_q.pop_front());
            res_ready = 1'b1;
            @(negedge core_clk);
            res_ready = 1'b0;
            @(negedge core_clk);
        end
        check({9'h000, res_valid}, 10'h000);
    endtask : pop_all

    task automatic complete_run;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        #(40000 * 4);
        n_errors++;
        complete_run();
    end

    initial begin
        int k;
        reset_n      = 1'b0;
        analog_value = 10'h000;
        req_valid    = 1'b0;
        req_channel  = 4'h0;
        req_clocks   = 5'h0A;
        req_hold_cs  = 1'b0;
        res_ready    = 1'b0;
        prev_res     = adc_link_pkg::RES_RESET;
        n_errors     = 0;
        checked      = 0;
        rises        = 0;
        repeat (20) @(negedge core_clk);
        check({4'h0, converting, u_adc_link_if.cs_n, u_adc_link_if.dout_oe_n,
               u_adc_link_if.eoc, req_ready, res_valid}, 10'h01E);
        reset_n = 1'b1;
        @(negedge core_clk);
        // toggled select, every length, then a ninth against a full fifo
        for (k = 0; k < 9; k++) begin
            do_xfer(chs[k], lens[k], 1'b0, 10'(k * 83 + 17));
        end
        repeat (300) @(negedge core_clk);
        check({8'h00, req_ready, res_valid}, 10'h001);
        pop_all();
        // select held low: ten clocks, then sixteen (twelve clamps up)
        do_xfer(4'h3, 5'h0A, 1'b1, 10'h2C7);
        do_xfer(4'hD, 5'h0A, 1'b1, 10'h111);
        do_xfer(4'h8, 5'h0A, 1'b0, 10'h0F0);
        pop_all();
        do_xfer(4'hC, 5'h0C, 1'b1, 10'h355);
        do_xfer(4'h2, 5'h10, 1'b1, 10'h0AA);
        do_xfer(4'h9, 5'h10, 1'b0, 10'h1E3);
        pop_all();
        complete_run();
    end
endmodule : adc_serial_conversion_control_tb
